// ### design/iosm_bank.sv
/*
  Local register bank of the slot mapper: a two-port word memory.
  Assumes one clock; port A belongs to the network side, port B to the application.
*/
`timescale 1ns/1ps

module iosm_bank #(
  parameter int AW = 13,
  parameter int DW = 16
) (
  // Clock
  input wire logic clock,
  // Port A, network side
  input wire logic aWe,
  input wire logic [AW-1:0] aAddr,
  input wire logic [DW-1:0] aWdata,
  output logic [DW-1:0] aRdata,
  // Port B, application side
  input wire logic bWe,
  input wire logic [AW-1:0] bAddr,
  input wire logic [DW-1:0] bWdata,
  output logic [DW-1:0] bRdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Port A is written last so it wins a same-address collision
  always_ff @(posedge clock) begin
    if (bWe) begin
      mem[bAddr] <= bWdata;
    end
    if (aWe) begin
      mem[aAddr] <= aWdata;
    end
  end

  // Read data are registered; a read sees the word as it was before a same-cycle write
  always_ff @(posedge clock) begin
    aRdata <= mem[aAddr];
  end

  always_ff @(posedge clock) begin
    bRdata <= mem[bAddr];
  end

endmodule // iosm_bank

// ### design/iosm_mapper.sv
/*
  Slot mapper package and top module: moves cyclic network data between nine
  slots and the local register bank, checks module plug-in, restarts on commit.
  Assumes the network stream logic and the configuration loader share clock.
*/

// What this block does
// R1 - Nine slots; 1-6 input, 7-9 output, 1440 bytes
// R2 - Module sizes 64, 128, 256, 512 bytes only
// R3 - One local register holds two data bytes
// R4 - Inputs go to controller, outputs come from it
// R5 - Integer inputs 0x30-0x33, slots one to three
// R6 - Float inputs 0x34-0x37, slots four to six
// R7 - Integer outputs 0x40-0x43, slots seven to nine
// R8 - Integer inputs packed from register 1
// R9 - Float inputs from 1001, two registers each
// R10 - Outputs written packed from register 5001
// R11 - After config transfer, restart with new config
// R12 - Slot zero reserved, never carries data
// R13 - Input slot data comes from local registers; output slot data is written to them
// R14 - Reject mismatched modules, leave configuration unchanged

package iosm_pkg;
  // ----------------------------------------
  // Slots and limits
  // ----------------------------------------
  localparam int NUM_SLOTS = 9;
  localparam logic [3:0] SLOT_RESERVED = 4'h0;
  localparam logic [3:0] INT_IN_FIRST = 4'h1;
  localparam logic [3:0] INT_IN_LAST = 4'h3;
  localparam logic [3:0] FLT_IN_FIRST = 4'h4;
  localparam logic [3:0] FLT_IN_LAST = 4'h6;
  localparam logic [3:0] OUT_FIRST = 4'h7;
  localparam logic [3:0] OUT_LAST = 4'h9;
  localparam int DIR_MAX_BYTES = 1440;
  localparam int BYTES_PER_REG = 2;
  localparam logic [10:0] DIR_MAX_REGS = 11'(DIR_MAX_BYTES / BYTES_PER_REG);
  // ----------------------------------------
  // Module identifiers and sizes
  // ----------------------------------------
  localparam logic [7:0] ID_INT_IN_512 = 8'h30;
  localparam logic [7:0] ID_FLT_IN_512 = 8'h34;
  localparam logic [7:0] ID_OUT_512 = 8'h40;
  localparam logic [8:0] REGS_512 = 9'h100;
  // ----------------------------------------
  // Register bank layout
  // ----------------------------------------
  localparam int REG_AW = 13;
  localparam int REG_DW = 16;
  localparam logic [12:0] INT_IN_BASE = 13'h0001;
  localparam logic [12:0] FLT_IN_BASE = 13'h03E9;
  localparam logic [12:0] OUT_BASE = 13'h1389;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESTART_TIME_NS = 1000;
  localparam int RESTART_CYCLES = (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum {TX_IDLE, TX_FETCH, TX_WAIT, TX_HI, TX_LO} iosm_tx_t;

  // Low two identifier bits select 512, 256, 128 or 64 bytes
  function automatic logic [8:0] modRegs(input logic [7:0] id);
    modRegs = REGS_512 >> id[1:0];
  endfunction
endpackage

`timescale 1ns/1ps

module iosm_mapper (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration loader
  input wire logic cfgWrite,
  input wire logic [3:0] cfgSlot,
  input wire logic [7:0] cfgModuleId,
  input wire logic cfgCommit,
  output logic cfgAccept,
  output logic cfgReject,
  output logic restarting,
  // Input stream toward the controller
  input wire logic txStart,
  input wire logic txReady,
  output logic txValid,
  output logic [7:0] txData,
  output logic txFrameDone,
  // Output stream from the controller
  input wire logic rxStart,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic rxDropped,
  // Application access to the local registers
  input wire logic appWe,
  input wire logic [12:0] appAddr,
  input wire logic [15:0] appWdata,
  output logic [15:0] appRdata
);

  // ----------------------------------------
  // Slot tables
  // ----------------------------------------
  logic [7:0] stgId_reg [1:9];
  logic stgUsed_reg [1:9];
  logic [7:0] actId_reg [1:9];
  logic actUsed_reg [1:9];
  logic [8:0] stgRegs [1:9];
  logic [8:0] actRegs [1:9];
  logic [12:0] actBase [1:9];

  for (genvar s = 1; s <= iosm_pkg::NUM_SLOTS; s++) begin : gSlot
    assign stgRegs[s] = stgUsed_reg[s] ? iosm_pkg::modRegs(stgId_reg[s]) : 9'h000; // R3
    assign actRegs[s] = actUsed_reg[s] ? iosm_pkg::modRegs(actId_reg[s]) : 9'h000; // R3
    if (s == int'(iosm_pkg::INT_IN_FIRST)) begin : gIntBase
      assign actBase[s] = iosm_pkg::INT_IN_BASE; // R8
    end else if (s == int'(iosm_pkg::FLT_IN_FIRST)) begin : gFltBase
      assign actBase[s] = iosm_pkg::FLT_IN_BASE; // R9
    end else if (s == int'(iosm_pkg::OUT_FIRST)) begin : gOutBase
      assign actBase[s] = iosm_pkg::OUT_BASE; // R10
    end else begin : gChain
      // Modules of one kind sit back to back; an empty slot takes no registers
      assign actBase[s] = actBase[s-1] + 13'(actRegs[s-1]); // R8 R9 R10
    end
  end

  // ----------------------------------------
  // Plug-in check
  // ----------------------------------------
  logic slotInt, slotFlt, slotOut, familyOk, sizeOk;
  logic [10:0] dirSum;
  logic restartBusy;

  assign slotInt = cfgSlot >= iosm_pkg::INT_IN_FIRST && cfgSlot <= iosm_pkg::INT_IN_LAST;
  assign slotFlt = cfgSlot >= iosm_pkg::FLT_IN_FIRST && cfgSlot <= iosm_pkg::FLT_IN_LAST;
  assign slotOut = cfgSlot >= iosm_pkg::OUT_FIRST && cfgSlot <= iosm_pkg::OUT_LAST;

  // Slot zero and slots past nine fall in no range and are always refused
  assign familyOk = (slotInt && cfgModuleId[7:2] == iosm_pkg::ID_INT_IN_512[7:2]) // R5 R12
                 || (slotFlt && cfgModuleId[7:2] == iosm_pkg::ID_FLT_IN_512[7:2]) // R6
                 || (slotOut && cfgModuleId[7:2] == iosm_pkg::ID_OUT_512[7:2]); // R7 R2

  // Registers already staged in the same direction, the replaced slot left out
  always_comb begin
    dirSum = 11'(iosm_pkg::modRegs(cfgModuleId));
    for (int s = 1; s <= iosm_pkg::NUM_SLOTS; s++) begin
      if (4'(s) != cfgSlot && ((4'(s) >= iosm_pkg::OUT_FIRST) == slotOut)) begin
        dirSum = dirSum + 11'(stgRegs[s]);
      end
    end
  end

  assign sizeOk = dirSum <= iosm_pkg::DIR_MAX_REGS; // R1

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfgAccept <= 1'b0;
      cfgReject <= 1'b0;
    end else begin
      cfgAccept <= cfgWrite && !restartBusy && familyOk && sizeOk;
      cfgReject <= cfgWrite && !(!restartBusy && familyOk && sizeOk); // R14
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int s = 1; s <= iosm_pkg::NUM_SLOTS; s++) begin
        stgId_reg[s] <= 8'h00;
        stgUsed_reg[s] <= 1'b0;
      end
    end else if (cfgWrite && !restartBusy && familyOk && sizeOk) begin
      // A refused module leaves the staged table untouched
      stgId_reg[cfgSlot] <= cfgModuleId; // R14
      stgUsed_reg[cfgSlot] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Restart on commit
  // ----------------------------------------
  logic [$clog2(iosm_pkg::RESTART_CYCLES+1)-1:0] restartCnt_reg;

  assign restartBusy = restartCnt_reg != '0;
  assign restarting = restartBusy;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      restartCnt_reg <= '0;
    end else if (cfgCommit && !restartBusy) begin
      restartCnt_reg <= ($bits(restartCnt_reg))'(iosm_pkg::RESTART_CYCLES); // R11
    end else if (restartBusy) begin
      restartCnt_reg <= restartCnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int s = 1; s <= iosm_pkg::NUM_SLOTS; s++) begin
        actId_reg[s] <= 8'h00;
        actUsed_reg[s] <= 1'b0;
      end
    end else if (cfgCommit && !restartBusy) begin
      for (int s = 1; s <= iosm_pkg::NUM_SLOTS; s++) begin
        actId_reg[s] <= stgId_reg[s]; // R11
        actUsed_reg[s] <= stgUsed_reg[s];
      end
    end
  end

  // ----------------------------------------
  // Network port of the register bank
  // ----------------------------------------
  logic bankWe;
  logic [12:0] bankAddr, txAddr, rxAddr;
  logic [15:0] bankRdata;
  logic [7:0] rxHi_reg;

  iosm_bank #(.AW(iosm_pkg::REG_AW), .DW(iosm_pkg::REG_DW)) uBank (
    .clock(clock),
    .aWe(bankWe),
    .aAddr(bankAddr),
    .aWdata({rxHi_reg, rxData}),
    .aRdata(bankRdata),
    .bWe(appWe),
    .bAddr(appAddr),
    .bWdata(appWdata),
    .bRdata(appRdata)
  ); // R13

  // Writes from the output stream win the port; a pending read waits a cycle
  assign bankAddr = bankWe ? rxAddr : txAddr;

  // ----------------------------------------
  // Input stream: slots one to six, high byte first
  // ----------------------------------------
  iosm_pkg::iosm_tx_t txState_reg;
  logic [3:0] txSlot_reg;
  logic [8:0] txIdx_reg;
  logic [7:0] txLow_reg;
  logic txSlotUsed;

  assign txSlotUsed = txSlot_reg <= iosm_pkg::FLT_IN_LAST && txSlot_reg != 4'h0
                    && actUsed_reg[txSlot_reg];
  assign txAddr = txSlotUsed ? actBase[txSlot_reg] + 13'(txIdx_reg) : 13'h0000;
  assign txValid = txState_reg == iosm_pkg::TX_HI || txState_reg == iosm_pkg::TX_LO;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txState_reg <= iosm_pkg::TX_IDLE;
      txSlot_reg <= 4'h1;
      txIdx_reg <= 9'h000;
      txData <= 8'h00;
      txLow_reg <= 8'h00;
      txFrameDone <= 1'b0;
    end else begin
      txFrameDone <= 1'b0;
      if (restartBusy) begin
        txState_reg <= iosm_pkg::TX_IDLE;
      end else begin
        unique case (txState_reg)
          iosm_pkg::TX_IDLE: begin
            if (txStart) begin
              txSlot_reg <= iosm_pkg::INT_IN_FIRST; // R4
              txIdx_reg <= 9'h000;
              txState_reg <= iosm_pkg::TX_FETCH;
            end
          end
          iosm_pkg::TX_FETCH: begin
            if (txSlot_reg > iosm_pkg::FLT_IN_LAST) begin
              txFrameDone <= 1'b1; // R1
              txState_reg <= iosm_pkg::TX_IDLE;
            end else if (!txSlotUsed) begin
              txSlot_reg <= txSlot_reg + 4'h1;
            end else if (!bankWe) begin
              txState_reg <= iosm_pkg::TX_WAIT; // R13
            end
          end
          iosm_pkg::TX_WAIT: begin
            txData <= bankRdata[15:8]; // R3
            txLow_reg <= bankRdata[7:0];
            txState_reg <= iosm_pkg::TX_HI;
          end
          iosm_pkg::TX_HI: begin
            if (txReady) begin
              txData <= txLow_reg;
              txState_reg <= iosm_pkg::TX_LO;
            end
          end
          iosm_pkg::TX_LO: begin
            if (txReady) begin
              if (txIdx_reg + 9'h001 == actRegs[txSlot_reg]) begin
                txIdx_reg <= 9'h000;
                txSlot_reg <= txSlot_reg + 4'h1;
              end else begin
                txIdx_reg <= txIdx_reg + 9'h001;
              end
              txState_reg <= iosm_pkg::TX_FETCH;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Output stream: slots seven to nine, high byte first
  // ----------------------------------------
  logic [3:0] rxSlot_reg;
  logic [8:0] rxIdx_reg;
  logic rxHaveHi_reg;
  logic rxInRange, rxSlotUsed, rxTake;

  assign rxInRange = rxSlot_reg <= iosm_pkg::OUT_LAST;
  assign rxSlotUsed = rxInRange && actUsed_reg[rxSlot_reg];
  // Stall during restart, on rxStart and while the pointer skips empty slots; past slot nine bytes are dropped
  assign rxReady = !restartBusy && !rxStart && (rxSlotUsed || !rxInRange);
  assign rxTake = rxValid && rxReady && rxSlotUsed;
  assign bankWe = rxTake && rxHaveHi_reg; // R10
  assign rxAddr = rxSlotUsed ? actBase[rxSlot_reg] + 13'(rxIdx_reg) : 13'h0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxSlot_reg <= iosm_pkg::OUT_FIRST;
      rxIdx_reg <= 9'h000;
      rxHaveHi_reg <= 1'b0;
      rxHi_reg <= 8'h00;
    end else if (restartBusy || rxStart) begin
      rxSlot_reg <= iosm_pkg::OUT_FIRST; // R4
      rxIdx_reg <= 9'h000;
      rxHaveHi_reg <= 1'b0;
    end else if (rxInRange && !rxSlotUsed) begin
      rxSlot_reg <= rxSlot_reg + 4'h1;
    end else if (rxTake && !rxHaveHi_reg) begin
      rxHi_reg <= rxData; // R3
      rxHaveHi_reg <= 1'b1;
    end else if (rxTake) begin
      rxHaveHi_reg <= 1'b0;
      if (rxIdx_reg + 9'h001 == actRegs[rxSlot_reg]) begin
        rxIdx_reg <= 9'h000;
        rxSlot_reg <= rxSlot_reg + 4'h1;
      end else begin
        rxIdx_reg <= rxIdx_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxDropped <= 1'b0;
    end else begin
      rxDropped <= rxValid && rxReady && !rxInRange; // R1
    end
  end

endmodule // iosm_mapper

// ### dv/iosm_mapper_monitor.sv
/* Port checker of the slot mapper, bound into iosm_mapper.
   Assumes one clock and rst asynchronous, active high. */
`timescale 1ns/1ps

module iosm_mapper_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration
  input wire logic cfgWrite,
  input wire logic [3:0] cfgSlot,
  input wire logic [7:0] cfgModuleId,
  input wire logic cfgCommit,
  input wire logic cfgAccept,
  input wire logic cfgReject,
  input wire logic restarting,
  // Streams
  input wire logic txReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic rxReady
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Restart length exceeds any repetition count, so it is counted here
  logic [8:0] upCnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      upCnt <= 9'h000;
    end else begin
      upCnt <= restarting ? upCnt + 9'h001 : 9'h000;
    end
  end
  sequence sCommit;
    cfgCommit && !restarting;
  endsequence
  sequence sHeld;
    txValid && !txReady && !cfgCommit && !restarting;
  endsequence
  AST_ONE_ANSWER: assert property (cfgWrite |=> cfgAccept != cfgReject)
    else $error("plug not answered once");
  AST_SLOT_RANGE: assert property ((cfgWrite && (cfgSlot == 4'h0 || cfgSlot > 4'h9))
    |=> cfgReject) else $error("bad slot accepted");
  AST_INT_ID: assert property ((cfgWrite && cfgSlot inside {[4'h1:4'h3]}
    && !(cfgModuleId inside {[8'h30:8'h33]})) |=> cfgReject) else $error("int id");
  AST_FLT_ID: assert property ((cfgWrite && cfgSlot inside {[4'h4:4'h6]}
    && !(cfgModuleId inside {[8'h34:8'h37]})) |=> cfgReject) else $error("float id");
  AST_OUT_ID: assert property ((cfgWrite && cfgSlot inside {[4'h7:4'h9]}
    && !(cfgModuleId inside {[8'h40:8'h43]})) |=> cfgReject) else $error("out id");
  AST_CFG_BUSY: assert property (cfgWrite && restarting |=> cfgReject)
    else $error("plug taken in restart");
  AST_RESTART_GO: assert property (sCommit |=> restarting ##1 restarting)
    else $error("restart not begun");
  AST_RESTART_CAP: assert property (restarting |-> upCnt < 9'h0C8)
    else $error("restart too long");
  AST_RESTART_LEN: assert property ($fell(restarting) |-> upCnt == 9'h0C8)
    else $error("restart too short");
  AST_TX_HOLD: assert property (sHeld |=> txValid && $stable(txData))
    else $error("tx byte not held");
  AST_QUIET: assert property (restarting && $past(restarting) |-> !txValid && !rxReady)
    else $error("stream active in restart");
endmodule // iosm_mapper_monitor

bind iosm_mapper iosm_mapper_monitor iosm_mapper_monitor_inst (.clock, .rst, .cfgWrite,
  .cfgSlot, .cfgModuleId, .cfgCommit, .cfgAccept, .cfgReject, .restarting, .txReady,
  .txValid, .txData, .rxReady);

// ### dv/iosm_mapper_tb.sv
/* Self-checking bench of the slot mapper: plugs, commit, both streams.
   Assumes iosm_plc_model as the controller and the bound checker. */
`timescale 1ns/1ps

module iosm_mapper_tb;
  logic clock, rst, cfgWrite, cfgCommit, txStart, rxStart, appWe, slow;
  logic cfgAccept, cfgReject, restarting, txReady, txValid, txFrameDone;
  logic rxValid, rxReady, rxDropped;
  logic [3:0] cfgSlot;
  logic [7:0] cfgModuleId, txData, rxData;
  logic [12:0] appAddr;
  logic [15:0] appWdata, appRdata, w;
  int error_cnt, compares, cyc, drops, seed, n, b, outs, stg[10], act[10];
  bit inRst, txDone;
  logic [15:0] mem[int];
  logic [7:0] expQ[$];
  iosm_mapper iosm_mapper_inst (.clock, .rst, .cfgWrite, .cfgSlot, .cfgModuleId,
    .cfgCommit, .cfgAccept, .cfgReject, .restarting, .txStart, .txReady, .txValid,
    .txData, .txFrameDone, .rxStart, .rxValid, .rxData, .rxReady, .rxDropped, .appWe,
    .appAddr, .appWdata, .appRdata);
  iosm_plc_model plc (.clock, .slow, .txValid, .txData, .txReady, .rxReady, .rxValid,
    .rxData);
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    drops += rxDropped;
    if (txFrameDone === 1'b1) txDone = 1;
    if (cyc == 40000) begin
      error_cnt++;
      final_report;
    end
  end
  // ------
  // Expectation and access helpers
  // ------
  function automatic bit okPlug(int s, logic [7:0] id);
    int tot;
    tot = 256 >> id[1:0];
    if (s >= 1 && s <= 3 && (id < 8'h30 || id > 8'h33)) return 0;
    if (s >= 4 && s <= 6 && (id < 8'h34 || id > 8'h37)) return 0;
    if (s >= 7 && s <= 9 && (id < 8'h40 || id > 8'h43)) return 0;
    if (s < 1 || s > 9 || inRst) return 0;
    for (int i = 1; i <= 9; i++) if (i != s && (i > 6) == (s > 6)) tot += stg[i];
    return tot <= 720;
  endfunction
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic plug(logic [3:0] s, logic [7:0] id);
    bit ok;
    ok = okPlug(s, id);
    @(negedge clock) {cfgWrite, cfgSlot, cfgModuleId} = {1'b1, s, id};
    @(negedge clock) cfgWrite = 0;
    chk("cfgAccept", 16'(ok), 16'(cfgAccept));
    chk("cfgReject", 16'(!ok), 16'(cfgReject));
    if (ok) stg[s] = 256 >> id[1:0];
  endtask
  task automatic wr(int a);
    @(negedge clock) {appWe, appAddr, appWdata} = {1'b1, 13'(a), 16'($random(seed))};
    mem[a] = appWdata;
  endtask
  task automatic final_report;
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    seed = 32'h326da2b1;
    {rst, cfgWrite, cfgCommit, txStart, rxStart, appWe, slow} = 7'h40;
    {cfgSlot, cfgModuleId, appAddr, appWdata} = 41'h0;
    repeat (20) @(negedge clock);
    rst = 0;
    plug(1, 8'h30);
    plug(2, 8'h30);
    plug(3, 8'h30);
    plug(3, 8'h33);
    plug(0, 8'h30);
    plug(4, 8'h30);
    plug(4, 8'h36);
    plug(7, 8'h43);
    plug(8, 8'h33);
    repeat (40) plug(4'($random(seed)), 8'h30 + 8'({$random(seed)} % 20));
    for (int a = 1; a <= 720; a++) wr(a);
    for (int a = 1001; a <= 1720; a++) wr(a);
    @(negedge clock) {appWe, cfgCommit} = 2'h1;
    act = stg;
    inRst = 1;
    @(negedge clock) cfgCommit = 0;
    n = restarting;
    plug(5, 8'h35);
    n += 2;
    repeat (250) @(negedge clock) n += restarting;
    inRst = 0;
    chk("restartLen", 200, 16'(n));
    b = 1;
    for (int s = 1; s <= 6; s++) begin
      if (s == 4) b = 1001;
      for (int r = 0; r < act[s]; r++) begin
        expQ.push_back(mem[b][15:8]);
        expQ.push_back(mem[b][7:0]);
        b++;
      end
    end
    outs = act[7] + act[8] + act[9];
    slow = 1;
    @(negedge clock) rxStart = 1;
    @(negedge clock) {rxStart, txStart} = 2'h1;
    for (int k = 0; k < outs; k++) begin
      w = 16'($random(seed));
      mem[5001 + k] = w;
      plc.rxQ.push_back(w[15:8]);
      plc.rxQ.push_back(w[7:0]);
    end
    repeat (4) plc.rxQ.push_back(8'h5A);
    @(negedge clock) txStart = 0;
    for (n = 0; n < 20000 && !(txDone && plc.rxQ.size() == 0); n++) @(negedge clock);
    repeat (10) @(negedge clock);
    chk("txCount", 16'(expQ.size()), 16'(plc.txQ.size()));
    chk("txDone", 16'h0001, 16'(txDone));
    foreach (expQ[i]) chk("txByte", 16'(expQ[i]), 16'(plc.txQ[i]));
    chk("rxDrops", 4, 16'(drops));
    for (int k = 5001; k < 5001 + outs; k++) begin
      @(negedge clock) appAddr = 13'(k);
      @(negedge clock) chk("outReg", mem[k], appRdata);
    end
    // Reset in mid-run empties both tables, so a first plug must be taken again
    rst = 1;
    repeat (3) @(negedge clock);
    rst = 0;
    chk("restartRst", 16'h0000, 16'(restarting));
    foreach (stg[i]) stg[i] = 0;
    plug(1, 8'h30);
    final_report;
  end
endmodule // iosm_mapper_tb

// ### dv/iosm_plc_model.sv
/* Behavioural IO controller facing the slot mapper streams.
   Assumes the bench fills rxQ and reads txQ by hierarchy. */
`timescale 1ns/1ps

module iosm_plc_model (
  // Clock and pace
  input wire logic clock,
  input wire logic slow,
  // Input stream
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  // Output stream
  input wire logic rxReady,
  output logic rxValid,
  output logic [7:0] rxData
);
  logic [7:0] txQ[$];
  logic [7:0] rxQ[$];
  logic taken;
  initial begin
    {txReady, rxValid, taken, rxData} = 11'h000;
  end
  always @(posedge clock) begin
    if (txValid && txReady) txQ.push_back(txData);
    taken <= rxValid && rxReady;
  end
  // Released data line toggles so a stale byte never looks valid
  always @(negedge clock) begin
    txReady <= slow ? ~txReady : 1'b1;
    if (taken && slow) begin
      rxValid <= 1'b0;
      rxData <= ~rxData;
    end else if ((taken || !rxValid) && rxQ.size() > 0) begin
      rxValid <= 1'b1;
      rxData <= rxQ.pop_front();
    end else if (taken || !rxValid) begin
      rxValid <= 1'b0;
      rxData <= ~rxData;
    end
  end
endmodule // iosm_plc_model
